// [design/qml_loader.sv]
// Quant matrix load command parser with matrix store and read port
`timescale 1ns/1ps
`default_nettype none

module qml_loader (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic cmd_valid_in,
    input wire logic [31:0] cmd_data_in,
    output logic cmd_ready_out,
    input wire logic scaling_lists_enabled_in,
    input wire logic large_transform_allowed_in,
    input wire logic [2:0] rd_index_in,
    input wire logic [5:0] rd_pos_in,
    output logic [7:0] rd_entry_out,
    output logic busy_out,
    output logic done_out,
    output logic cmd_error_out
);

    qml_pkg::qml_st_t s_q; // Registered state
    qml_pkg::qml_st_t s_d; // Next state
    logic [7:0] mem [qml_pkg::MEM_BYTES]; // Stored list bytes

    logic fifo_valid; // Dword waiting at FIFO head
    logic [31:0] fifo_data; // Dword at FIFO head
    logic take; // Parser consumes the head dword this cycle
    qml_pkg::qml_hdr_t hdr; // Head dword viewed as header
    qml_pkg::qml_flags_t flg; // Head dword viewed as flags
    logic wr_en; // Write the head dword's bytes into storage
    logic [7:0] wr_addr; // Storage address of byte lane 0
    logic last_dw; // Head dword completes the current matrix
    logic [7:0] pres_left; // Present lists still awaited
    qml_pkg::qml_src_t rd_src; // Source of the list being read
    logic [7:0] rd_mem; // Stored byte for the read request

    // Command dwords pass a short buffer so the streamer is not
    // stalled by the commit cycle that ends each command
    qml_fifo #(
        .WIDTH(32),
        .DEPTH(4)
    ) u_fifo (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .in_valid_in(cmd_valid_in),
        .in_data_in(cmd_data_in),
        .in_ready_out(cmd_ready_out),
        .out_valid_out(fifo_valid),
        .out_data_out(fifo_data),
        .out_ready_in(take)
    );

    // Base byte address of a list in storage
    function automatic logic [7:0] list_base(input logic [2:0] idx);
        logic [7:0] b;
        if (idx >= qml_pkg::IDX_8X8_FIRST) begin
            b = qml_pkg::BASE_8X8
                + {1'b0, idx[0], 6'h00};
        end else begin
            b = {1'b0, idx, 4'h0};
        end
        return b;
    endfunction : list_base

    // Lowest set bit of a mask, ascending index order
    function automatic logic [2:0] first_set(input logic [7:0] m);
        logic [2:0] r;
        r = '0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : first_set

    // Built-in default entry at a raster position of a list
    function automatic logic [7:0] dflt_entry(input logic [2:0] idx,
                                              input logic [5:0] pos);
        logic [2:0] r;
        logic [2:0] c;
        logic [3:0] d;
        logic [7:0] v;
        if (idx >= qml_pkg::IDX_8X8_FIRST) begin
            r = pos[5:3];
            c = pos[2:0];
            d = {1'b0, r} + {1'b0, c};
            if (r == qml_pkg::POS_ONE && c == qml_pkg::POS_ONE) begin
                v = idx[0] ? qml_pkg::DFLT8_INTER_D11
                           : qml_pkg::DFLT8_INTRA_D11;
            end else begin
                v = idx[0] ? qml_pkg::DFLT8_INTER[d]
                           : qml_pkg::DFLT8_INTRA[d];
            end
        end else begin
            r = {1'b0, pos[3:2]};
            c = {1'b0, pos[1:0]};
            d = {1'b0, r} + {1'b0, c};
            v = (idx >= qml_pkg::IDX_4X4_INTER)
                ? qml_pkg::DFLT4_INTER[d[2:0]]
                : qml_pkg::DFLT4_INTRA[d[2:0]];
        end
        return v;
    endfunction : dflt_entry

    assign hdr = qml_pkg::qml_hdr_t'(fifo_data);
    assign flg = qml_pkg::qml_flags_t'(fifo_data);

    // Stall only in the commit cycle; the FIFO absorbs the gap
    assign take = fifo_valid && (s_q.st != qml_pkg::QML_ST_COMMIT);

    // Read port lookup: follow the list's source to storage or table
    always_comb begin
        rd_src = s_q.src[rd_index_in];
        rd_mem = mem[list_base(rd_src.idx) + {2'b00, rd_pos_in}];
    end

    // Parser, matrix placement and commit
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.err = 1'b0;
        wr_en = 1'b0;
        wr_addr = list_base(s_q.cur) + {2'b00, s_q.dw_ptr, 2'b00};
        last_dw = (s_q.cur >= qml_pkg::IDX_8X8_FIRST)
            ? (s_q.dw_ptr == qml_pkg::DW_8X8_LAST)
            : (s_q.dw_ptr == qml_pkg::DW_4X4_LAST);
        pres_left = s_q.pres;
        pres_left[s_q.cur] = 1'b0;
        // Table reads use the requested list's own kind, which also
        // covers a fallback that ends on a default list
        s_d.rd_entry = rd_src.dflt ? dflt_entry(rd_index_in, rd_pos_in)
                                   : rd_mem;
        case (s_q.st)
            qml_pkg::QML_ST_HEADER: begin
                if (take) begin
                    // Any header is consumed by its own length so the
                    // stream stays aligned even for a stray command
                    s_d.rem = hdr.dw_len;
                    s_d.hdr_ok = hdr.cmd_type == qml_pkg::HDR_CMD_TYPE
                        && hdr.pipeline == qml_pkg::HDR_PIPELINE
                        && hdr.opcode == qml_pkg::HDR_OPCODE
                        && hdr.sub_opcode == qml_pkg::HDR_SUB_OPCODE
                        && hdr.dw_len <= qml_pkg::HDR_MAX_LEN;
                    s_d.err = !s_d.hdr_ok;
                    s_d.busy = 1'b1;
                    s_d.st = qml_pkg::QML_ST_FLAGS;
                end
            end
            qml_pkg::QML_ST_FLAGS: begin
                if (take) begin
                    // Data is dropped when lists are off or header bad
                    s_d.accept = s_q.hdr_ok
                        && scaling_lists_enabled_in;
                    s_d.dflt = flg.use_default;
                    // 8x8 lists count as absent without the large
                    // transform, so they fall back rather than point
                    // at bytes that this command never wrote
                    s_d.list = flg.matrix_list_included
                        & (large_transform_allowed_in
                           ? qml_pkg::LIST_ALL_MASK
                           : qml_pkg::LIST_4X4_MASK);
                    // Only included, non-default lists carry bytes,
                    // and 8x8 lists only with the large transform
                    s_d.pres = flg.matrix_list_included
                        & ~flg.use_default
                        & (large_transform_allowed_in
                           ? qml_pkg::LIST_ALL_MASK
                           : qml_pkg::LIST_4X4_MASK);
                    s_d.cur = first_set(s_d.pres);
                    s_d.dw_ptr = '0;
                    s_d.st = (s_q.rem == '0) ? qml_pkg::QML_ST_COMMIT
                                             : qml_pkg::QML_ST_PAYLOAD;
                end
            end
            qml_pkg::QML_ST_PAYLOAD: begin
                if (take) begin
                    s_d.rem = s_q.rem - 1'b1;
                    // Dwords beyond the last present list are dropped
                    wr_en = s_q.accept && (s_q.pres != '0);
                    if (s_q.pres != '0) begin
                        if (last_dw) begin
                            // Matrix filled: move to next higher list
                            s_d.pres = pres_left;
                            s_d.cur = first_set(pres_left);
                            s_d.dw_ptr = '0;
                        end else begin
                            s_d.dw_ptr = s_q.dw_ptr + 1'b1;
                        end
                    end
                    if (s_q.rem == 16'h0001) begin
                        s_d.st = qml_pkg::QML_ST_COMMIT;
                    end
                end
            end
            qml_pkg::QML_ST_COMMIT: begin
                // Sources change only on an accepted command or a reset, so the
                // previous set survives everything else
                if (s_q.accept) begin
                    for (int i = 0; i < 8; i++) begin
                        if (s_q.list[i]) begin
                            s_d.src[i] = '{dflt: s_q.dflt[i],
                                           idx: 3'(i)};
                        end else if (qml_pkg::FB_ROOT_MASK[i]) begin
                            s_d.src[i] = qml_pkg::SRC_DEFAULT;
                        end else begin
                            s_d.src[i] = s_d.src[i - 1];
                        end
                    end
                end
                s_d.done = 1'b1;
                s_d.busy = 1'b0;
                s_d.st = qml_pkg::QML_ST_HEADER;
            end
            default: begin
                s_d.st = qml_pkg::QML_ST_HEADER;
            end
        endcase
    end

    // State register; reset brings back built-in defaults for all
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s_q <= qml_pkg::QML_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // One byte lane per dword byte, lowest byte is earliest entry
    for (genvar b = 0; b < qml_pkg::BYTE_LANES; b++) begin : g_lane
        always_ff @(posedge clk_in) begin
            if (wr_en) begin
                mem[wr_addr + 8'(b)] <= fifo_data[b*8 +: 8];
            end
        end
    end

    assign rd_entry_out = s_q.rd_entry;
    assign busy_out = s_q.busy;
    assign done_out = s_q.done;
    assign cmd_error_out = s_q.err;

    // Checks on the parser's own behaviour
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    // A command ends with one commit cycle then a done pulse
    sequence seq_last_payload;
        s_q.st == qml_pkg::QML_ST_PAYLOAD && take && s_q.rem == 16'h0001;
    endsequence
    sequence seq_commit_done;
        s_q.st == qml_pkg::QML_ST_COMMIT ##1 done_out;
    endsequence

    AST_DROP_DATA: assert property (wr_en |-> s_q.accept)
        else $error("write while data is being discarded");
    AST_LIST_LIMIT: assert property ((s_q.st == qml_pkg::QML_ST_FLAGS
        && take && !large_transform_allowed_in)
        |=> s_q.pres[7:6] == 2'b00 && s_q.list[7:6] == 2'b00)
        else $error("8x8 list expected without large transform");
    AST_DEFAULT_OMIT: assert property (s_q.st == qml_pkg::QML_ST_PAYLOAD
        |-> (s_q.pres & s_q.dflt) == '0)
        else $error("default list expected in payload");
    AST_ORDER: assert property ((wr_en && last_dw && pres_left != '0)
        |=> s_q.cur > $past(s_q.cur))
        else $error("lists not taken in ascending order");
    AST_KEEP: assert property ((s_q.st != qml_pkg::QML_ST_COMMIT
        || !s_q.accept) |=> $stable(s_q.src))
        else $error("matrix sources changed outside commit");
    AST_HDR_ERR: assert property ((s_q.st == qml_pkg::QML_ST_HEADER
        && take && hdr.opcode != qml_pkg::HDR_OPCODE)
        |=> cmd_error_out && !s_q.hdr_ok)
        else $error("bad header not flagged");
    AST_EXACT_LEN: assert property (seq_last_payload
        |=> seq_commit_done)
        else $error("command end not followed by commit and done");
    AST_SELECT_DEFAULT: assert property ((s_q.st == qml_pkg::QML_ST_COMMIT
        && s_q.accept && s_q.list[0] && s_q.dflt[0])
        |=> s_q.src[0].dflt)
        else $error("default flag did not select default list");
    AST_PRESENT_ONLY: assert property (wr_en |-> s_q.pres[s_q.cur])
        else $error("write to a list that is not present");
    AST_FALLBACK: assert property ((s_q.st == qml_pkg::QML_ST_COMMIT
        && s_q.accept && !s_q.list[1])
        |=> s_q.src[1] == $past(s_d.src[0]))
        else $error("missing list did not fall back to its neighbour");

endmodule : qml_loader

`default_nettype wire

// [design/qml_pkg.sv]
// Shared types and constants of the quantization-matrix state loader
package qml_pkg;

    // Command header encoding that marks a quant_matrix_load_command
    localparam logic [2:0] HDR_CMD_TYPE = 3'h3;
    localparam logic [1:0] HDR_PIPELINE = 2'h2;
    localparam logic [2:0] HDR_OPCODE = 3'h4;
    localparam logic [7:0] HDR_SUB_OPCODE = 8'h01;
    // Largest legal payload dword count (header and flags excluded)
    localparam logic [15:0] HDR_MAX_LEN = 16'h0038;

    // Matrix numbering: 0..5 are 4x4 lists, 6..7 are 8x8 luma lists
    localparam logic [2:0] IDX_4X4_INTER = 3'h3;
    localparam logic [2:0] IDX_8X8_FIRST = 3'h6;
    // Lists that may follow when the large transform is off
    localparam logic [7:0] LIST_4X4_MASK = 8'h3f;
    localparam logic [7:0] LIST_ALL_MASK = 8'hff;
    // Lists whose fallback is the built-in default, not a neighbour
    localparam logic [7:0] FB_ROOT_MASK = 8'hc9;

    // Dwords per matrix, as last dword number within the matrix
    localparam logic [3:0] DW_4X4_LAST = 4'h3;
    localparam logic [3:0] DW_8X8_LAST = 4'hf;
    // Byte storage layout: six 16-byte lists then two 64-byte lists
    localparam int MEM_BYTES = 224;
    localparam logic [7:0] BASE_8X8 = 8'h60;
    localparam int BYTE_LANES = 4;

    // Built-in defaults; both depend only on row plus column,
    // apart from the 8x8 entry at row 1, column 1
    localparam logic [6:0][7:0] DFLT4_INTRA =
        {8'h2a, 8'h25, 8'h20, 8'h1c, 8'h14, 8'h0d, 8'h06};
    localparam logic [6:0][7:0] DFLT4_INTER =
        {8'h22, 8'h1e, 8'h1b, 8'h18, 8'h14, 8'h0e, 8'h0a};
    localparam logic [14:0][7:0] DFLT8_INTRA =
        {8'h2a, 8'h28, 8'h26, 8'h24, 8'h21, 8'h1f, 8'h1d, 8'h1b,
         8'h19, 8'h17, 8'h12, 8'h10, 8'h0d, 8'h0a, 8'h06};
    localparam logic [14:0][7:0] DFLT8_INTER =
        {8'h23, 8'h21, 8'h20, 8'h1e, 8'h1c, 8'h1b, 8'h19, 8'h18,
         8'h16, 8'h15, 8'h13, 8'h11, 8'h0f, 8'h0d, 8'h09};
    localparam logic [7:0] DFLT8_INTRA_D11 = 8'h0b;
    localparam logic [7:0] DFLT8_INTER_D11 = 8'h0d;
    localparam logic [2:0] POS_ONE = 3'h1;

    // Header dword as fields
    typedef struct packed {
        logic [2:0] cmd_type;
        logic [1:0] pipeline;
        logic [2:0] opcode;
        logic [7:0] sub_opcode;
        logic [15:0] dw_len;
    } qml_hdr_t;

    // Flags dword as fields
    typedef struct packed {
        logic [15:0] reserved;
        logic [7:0] use_default;
        logic [7:0] matrix_list_included;
    } qml_flags_t;

    // Where a list's entries come from: default table or stored list
    typedef struct packed {
        logic dflt;
        logic [2:0] idx;
    } qml_src_t;

    localparam qml_src_t SRC_DEFAULT = '{dflt: 1'b1, idx: 3'h0};

    // Parser states
    typedef enum logic [1:0] {
        QML_ST_HEADER,
        QML_ST_FLAGS,
        QML_ST_PAYLOAD,
        QML_ST_COMMIT
    } qml_state_t;

    // Whole state of the loader
    typedef struct packed {
        qml_state_t st;
        logic [15:0] rem;
        logic hdr_ok;
        logic accept;
        logic [2:0] cur;
        logic [3:0] dw_ptr;
        logic [7:0] pres;
        logic [7:0] list;
        logic [7:0] dflt;
        qml_src_t [7:0] src;
        logic busy;
        logic done;
        logic err;
        logic [7:0] rd_entry;
    } qml_st_t;

    localparam qml_st_t QML_RESET = '{st: QML_ST_HEADER,
                                      src: {8{SRC_DEFAULT}},
                                      default: '0};

endpackage : qml_pkg

// [design/qml_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module qml_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // Pointers, fill count and registered ready
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic rdy;
    } fifo_st_t;

    fifo_st_t s_q; // Registered state
    fifo_st_t s_d; // Next state
    logic [WIDTH-1:0] mem [DEPTH]; // Word storage
    logic push; // Word accepted on the filling side
    logic pop; // Word taken on the draining side

    // Ready is registered so the source sees a clean flop output
    always_comb begin
        s_d = s_q;
        push = in_valid_in && s_q.rdy;
        pop = out_valid_out && out_ready_in;
        if (push) begin
            s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
        s_d.rdy = (s_d.cnt != CW'(DEPTH));
    end

    // State register; empty and ready after reset
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s_q <= '{rdy: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Storage write; no reset needed, count guards every read
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[s_q.wp] <= in_data_in;
        end
    end

    assign in_ready_out = s_q.rdy;
    assign out_valid_out = (s_q.cnt != '0);
    assign out_data_out = mem[s_q.rp];

endmodule : qml_fifo

`default_nettype wire

// [bench/qml_cmd_src.sv]
// Command streamer model feeding command dwords to the loader
`timescale 1ns/1ps
`default_nettype none

module qml_cmd_src (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic slow_in,
    input wire logic ready_in,
    output logic valid_out,
    output logic [31:0] data_out
);
    logic [31:0] q[$]; // Dwords waiting to go out

    // Queue one dword; the bench calls this off the rising edge
    task automatic send(input logic [31:0] w);
        q.push_back(w);
    endtask : send

    initial begin
        valid_out = 1'b0;
        data_out = 32'h0000_0000;
    end

    // Hold each dword until taken; slow mode idles a cycle after each
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            valid_out <= 1'b0;
        end else if (!valid_out || ready_in) begin
            if (valid_out) begin
                void'(q.pop_front());
            end
            if (q.size() > 0 && !(slow_in && valid_out)) begin
                valid_out <= 1'b1;
                data_out <= q[0];
            end else begin
                // Released bus shows no stale value
                valid_out <= 1'b0;
                data_out <= ~data_out;
            end
        end
    end
endmodule : qml_cmd_src

`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the quant matrix loader
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_in;
    logic nrst_in;
    logic slow; // Streamer idles between dwords
    logic valid;
    logic [31:0] data;
    logic ready;
    logic en_q;
    logic lg_q;
    logic [2:0] idx;
    logic [5:0] pos;
    logic [7:0] entry;
    logic busy;
    logic done;
    logic err;
    int miscompares;
    int n_tests;
    int n_done;
    int n_err;
    logic [7:0] mem [8][64]; // Expected stored entries
    int src [8]; // 8 means built-in default, else stored list

    qml_cmd_src u_qml_cmd_src (.clk_in(clk_in), .nrst_in(nrst_in),
        .slow_in(slow), .ready_in(ready), .valid_out(valid),
        .data_out(data));

    qml_loader u_qml_loader (.clk_in(clk_in), .nrst_in(nrst_in),
        .cmd_valid_in(valid), .cmd_data_in(data), .cmd_ready_out(ready),
        .scaling_lists_enabled_in(en_q),
        .large_transform_allowed_in(lg_q), .rd_index_in(idx),
        .rd_pos_in(pos), .rd_entry_out(entry), .busy_out(busy),
        .done_out(done), .cmd_error_out(err));

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // Count the one-cycle pulses
    always @(posedge clk_in) begin
        if (done === 1'b1) n_done++;
        if (err === 1'b1) n_err++;
    end

    // Payload byte k of a command
    function automatic logic [7:0] pay(int k);
        return 8'(k * 7 + 3);
    endfunction : pay

    // Built-in default of list i at raster position p
    function automatic logic [7:0] dv(int i, int p);
        int r;
        int c;
        bit a;
        a = (i < 3) || (i == 6);
        r = (i < 6) ? p / 4 : p / 8;
        c = (i < 6) ? p % 4 : p % 8;
        if (i < 6)
            return a ? qml_pkg::DFLT4_INTRA[r+c] : qml_pkg::DFLT4_INTER[r+c];
        if (r == 1 && c == 1)
            return a ? qml_pkg::DFLT8_INTRA_D11 : qml_pkg::DFLT8_INTER_D11;
        return a ? qml_pkg::DFLT8_INTRA[r+c] : qml_pkg::DFLT8_INTER[r+c];
    endfunction : dv

    task automatic cmp8(logic [7:0] got, logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp8

    task automatic cmp_n(int got, int exp);
        n_tests++;
        if (got != exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_n

    // Expected effect of one accepted command
    task automatic model(logic [7:0] lst, logic [7:0] dft, bit lg, int n);
        int k;
        bit inc;
        k = 0;
        for (int i = 0; i < 8; i++) begin
            inc = lst[i] && (i < 6 || lg);
            if (inc && !dft[i]) begin
                for (int p = 0; p < (i < 6 ? 16 : 64); p++) begin
                    if (k / 4 < n) mem[i][p] = pay(k);
                    k++;
                end
                src[i] = i;
            end else if (inc) src[i] = 8;
            else if (i % 3 != 0 && i < 6) src[i] = src[i-1];
            else src[i] = 8;
        end
    endtask : model

    // Send one command and wait until it is fully consumed
    task automatic send_cmd(logic [7:0] sub, logic [15:0] len,
                            logic [7:0] lst, logic [7:0] dft, bit en, bit lg);
        int d0;
        int e0;
        int w;
        bit bad;
        d0 = n_done;
        e0 = n_err;
        bad = sub != qml_pkg::HDR_SUB_OPCODE || len > qml_pkg::HDR_MAX_LEN;
        @(posedge clk_in);
        en_q <= en;
        lg_q <= lg;
        @(negedge clk_in);
        u_qml_cmd_src.send({qml_pkg::HDR_CMD_TYPE, qml_pkg::HDR_PIPELINE,
                            qml_pkg::HDR_OPCODE, sub, len});
        u_qml_cmd_src.send({16'h0000, dft, lst});
        for (int d = 0; d < len; d++)
            u_qml_cmd_src.send({pay(4*d+3), pay(4*d+2), pay(4*d+1), pay(4*d)});
        w = 0;
        while (w < 600 && (u_qml_cmd_src.q.size() > 0 || valid || busy
               || n_done + n_err == d0 + e0)) begin
            @(posedge clk_in);
            w++;
        end
        repeat (4) @(posedge clk_in);
        cmp_n(n_err - e0, bad ? 1 : 0);
        cmp8({7'h00, busy}, 8'h00);
        cmp_n(n_done - d0, 1);
        if (!bad && en) model(lst, dft, lg, len);
    endtask : send_cmd

    // Read every entry of every list and compare
    task automatic check_all();
        for (int i = 0; i < 8; i++)
            for (int p = 0; p < (i < 6 ? 16 : 64); p++) begin
                @(posedge clk_in);
                idx <= 3'(i);
                pos <= 6'(p);
                @(posedge clk_in);
                #1 cmp8(entry, src[i] == 8 ? dv(i, p) : mem[src[i]][p]);
            end
    endtask : check_all

    task automatic t_load();
        @(posedge clk_in);
        slow <= 1'b1;
        send_cmd(8'h01, 16'd36, 8'hc5, 8'h04, 1'b1, 1'b1);
        check_all();
        slow <= 1'b0;
        $display("test load done");
    endtask : t_load

    task automatic t_bad();
        send_cmd(8'h02, 16'd4, 8'h01, 8'h00, 1'b1, 1'b1);
        send_cmd(8'h01, 16'h0039, 8'hff, 8'h00, 1'b1, 1'b1);
        check_all();
        $display("test bad headers done");
    endtask : t_bad

    task automatic t_reset();
        @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        foreach (src[i]) src[i] = 8;
        check_all();
        $display("test reset done");
    endtask : t_reset

    initial begin
        nrst_in = 1'b0;
        slow = 1'b0;
        en_q = 1'b0;
        lg_q = 1'b0;
        idx = 3'h0;
        pos = 6'h00;
        miscompares = 0;
        n_tests = 0;
        n_done = 0;
        n_err = 0;
        foreach (src[i]) src[i] = 8;
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        check_all();
        $display("test defaults done");
        t_load();
        send_cmd(8'h01, 16'd4, 8'h01, 8'h00, 1'b0, 1'b1);
        check_all();
        $display("test disabled done");
        send_cmd(8'h01, 16'd16, 8'h7a, 8'h00, 1'b1, 1'b0);
        check_all();
        $display("test small done");
        t_bad();
        send_cmd(8'h01, 16'h0038, 8'hff, 8'h00, 1'b1, 1'b1);
        check_all();
        $display("test max done");
        send_cmd(8'h01, 16'h0000, 8'h00, 8'h00, 1'b1, 1'b1);
        check_all();
        $display("test empty done");
        t_reset();
        conclude();
    end

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge clk_in);
        miscompares++;
        conclude();
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
endmodule : testbench

`default_nettype wire
